// ==== hdl/rvm_pkg.sv ====
// Shared constants for the regulator voltage monitor.
package rvm_pkg;

  // ----------------------------------------
  // Structure
  // ----------------------------------------
  localparam int NUM_SW  = 7;
  localparam int NUM_LIN = 4;
  localparam int NUM_REG = NUM_SW + NUM_LIN;
  localparam int TRIP_W  = 2;
  localparam int SEL_W   = 2;
  localparam int DB_W    = 7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_DB_US  [4] = '{5, 15, 25, 40};
  localparam int HIGH_DB_US [4] = '{25, 50, 80, 125};

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_ENABLE    = 8'h04;
  localparam logic [7:0] ADDR_KEY       = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;
  localparam logic [7:0] ADDR_TRIP_LOW  = 8'h18;
  localparam logic [7:0] ADDR_TRIP_HIGH = 8'h1C;

  localparam int CTRL_LOW_LSB  = 0;
  localparam int CTRL_HIGH_LSB = 2;
  localparam int CTRL_SECURE   = 4;
  localparam int STAT_HIGH_LSB = 16;

  localparam logic [SEL_W-1:0]   LOW_SEL_RST  = 2'h2;
  localparam logic [SEL_W-1:0]   HIGH_SEL_RST = 2'h0;
  localparam logic [NUM_REG-1:0] ENABLE_RST   = 11'h7FF;
  // Arbitrary unlock value for the secure write sequence.
  localparam logic [31:0]        SECURE_KEY   = 32'h0000_C3A5;

endpackage

// ==== hdl/rvm_tick.sv ====
// One-cycle enable pulse divider for the debounce time base.
`timescale 1ns/1ps
`default_nettype none
module rvm_tick #(
  parameter int DIV = 100
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Pulse
  output logic      tick_out
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q    <= 16'h0000;
      tick_out <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q    <= 16'h0000;
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 16'h0001;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/rvm_filter.sv ====
// Debounce filter for one comparator condition.
`timescale 1ns/1ps
`default_nettype none
module rvm_filter #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Control
  input  wire logic             tick_in,
  input  wire logic             active_in,
  input  wire logic [CNT_W-1:0] limit_in,
  // Condition and result
  input  wire logic             cond_in,
  output logic                  state_out
);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q     <= '0;
      state_out <= 1'b0;
    end else if (!active_in) begin
      cnt_q     <= '0;
      state_out <= 1'b0;
    end else if (cond_in == state_out) begin
      cnt_q <= '0;
    end else if (tick_in) begin
      if (cnt_q >= limit_in - 1'b1) begin
        cnt_q     <= '0;
        state_out <= cond_in;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_expire;
    tick_in && active_in && (cond_in != state_out) && (cnt_q >= limit_in - 1'b1);
  endsequence

  AST_FLT_EXPIRE: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(state_out) |-> ($past(active_in) ? $past(tick_in) : !state_out))
    else $error("Status changed without a completed debounce count.");

  AST_FLT_FLIP: assert property (@(posedge clk_in) disable iff (rst_in)
    s_expire |=> (state_out == $past(cond_in)) && (cnt_q == '0))
    else $error("Status did not follow after the debounce time.");

  AST_FLT_RESTART: assert property (@(posedge clk_in) disable iff (rst_in)
    active_in && (cond_in == state_out) |=> cnt_q == '0)
    else $error("Debounce count did not restart when the condition dropped.");

  AST_FLT_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    !active_in |=> !state_out)
    else $error("Status not cleared while supervision is off.");
endmodule
`default_nettype wire

// ==== hdl/rvm_monitor.sv ====
// Regulator voltage monitor: debounce, masking, status and APB registers.
//
// What this block does
// - Supervise seven switching and four linear outputs for low and high voltage.
// - Low trip code 00/01/10/11 selects 95/93/91/89 percent of nominal.
// - High trip code 00/01/10/11 selects 105/107/109/111 percent of nominal.
// - Shared low filter select gives 5, 15, 25 or 40 microseconds.
// - Full register reset loads low filter select with binary 10.
// - Shared high filter select gives 25, 50, 80 or 125 microseconds.
// - Full register reset loads high filter select with binary 00.
// - Per-regulator supervise enable: one supervises, zero stops supervision.
// - All supervise enable bits come up as one.
// - With secure protection set, only secure writes may change supervise enables.
// - A regulator being enabled is masked until it reaches regulation.
// - A disabled monitor forces its low and high status to zero.
`timescale 1ns/1ps
`default_nettype none
module rvm_monitor #(
  parameter int TICK_CYC = rvm_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                           CLK_IN,
  input  wire logic                           RST_IN,
  // APB slave
  input  wire logic                           PSEL_IN,
  input  wire logic                           PENABLE_IN,
  input  wire logic                           PWRITE_IN,
  input  wire logic [7:0]                     PADDR_IN,
  input  wire logic [31:0]                    PWDATA_IN,
  output logic      [31:0]                    PRDATA_OUT,
  output logic                                PREADY_OUT,
  output logic                                PSLVERR_OUT,
  // Comparators and regulator state
  input  wire logic [rvm_pkg::NUM_REG-1:0]    LOW_CMP_IN,
  input  wire logic [rvm_pkg::NUM_REG-1:0]    HIGH_CMP_IN,
  input  wire logic [rvm_pkg::NUM_REG-1:0]    REG_ON_IN,
  input  wire logic [rvm_pkg::NUM_REG-1:0]    REG_READY_IN,
  // Trip code configuration
  input  wire logic [2*rvm_pkg::NUM_SW-1:0]   SWITCHER_LOW_TRIP_CODE_IN,
  input  wire logic [2*rvm_pkg::NUM_LIN-1:0]  LINEAR_LOW_TRIP_CODE_IN,
  input  wire logic [2*rvm_pkg::NUM_SW-1:0]   SWITCHER_HIGH_TRIP_CODE_IN,
  input  wire logic [2*rvm_pkg::NUM_LIN-1:0]  LINEAR_HIGH_TRIP_CODE_IN,
  output logic      [2*rvm_pkg::NUM_REG-1:0]  LOW_TRIP_CODE_OUT,
  output logic      [2*rvm_pkg::NUM_REG-1:0]  HIGH_TRIP_CODE_OUT,
  // Supervision results
  output logic      [rvm_pkg::NUM_REG-1:0]    SUPERVISE_ENABLE_OUT,
  output logic      [rvm_pkg::NUM_REG-1:0]    LOW_VOLTAGE_STATUS_OUT,
  output logic      [rvm_pkg::NUM_REG-1:0]    HIGH_VOLTAGE_STATUS_OUT,
  output logic                                IRQ_OUT
);
  localparam int N  = rvm_pkg::NUM_REG;
  localparam int SW = rvm_pkg::SEL_W;
  localparam int DW = rvm_pkg::DB_W;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [SW-1:0] low_sel_q;
  logic [SW-1:0] high_sel_q;
  logic          secure_q;
  logic          armed_q;
  logic [N-1:0]  sup_en_q;
  logic [N-1:0]  mask_q;
  logic [N-1:0]  reg_on_q;
  logic [N-1:0]  on_rise;
  logic [N-1:0]  new_mask;
  logic [N-1:0]  active;
  logic [N-1:0]  low_prev_q;
  logic [N-1:0]  high_prev_q;
  logic [N-1:0]  irq_low_q;
  logic [N-1:0]  irq_high_q;
  logic [N-1:0]  irqm_low_q;
  logic [N-1:0]  irqm_high_q;
  logic          load_done_q;
  logic          ctrl_wr_q;
  logic          en_wr_q;
  logic          tick;
  logic [DW-1:0] low_limit;
  logic [DW-1:0] high_limit;
  logic          acc;
  logic          do_ans;
  logic          do_cmt;
  logic          wr_cmt;
  logic          en_locked;
  logic [31:0]   rd_data;
  logic          rd_err;

  // ----------------------------------------
  // Filter time lookup
  // ----------------------------------------
  // A filter time is a least time, so it rounds up to whole ticks.
  function automatic logic [DW-1:0] db_ticks(input int us);
    int ns;
    ns = us * rvm_pkg::NS_PER_US;
    return DW'((ns + rvm_pkg::TICK_NS - 1) / rvm_pkg::TICK_NS);
  endfunction

  assign low_limit  = db_ticks(rvm_pkg::LOW_DB_US[low_sel_q]);
  assign high_limit = db_ticks(rvm_pkg::HIGH_DB_US[high_sel_q]);

  rvm_tick #(
    .DIV (TICK_CYC)
  ) u_tick (
    .clk_in   (CLK_IN),
    .rst_in   (RST_IN),
    .tick_out (tick)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // One wait state: the answer is prepared in the first access cycle,
  // and a write takes effect at the edge where PREADY is sampled high.
  assign acc       = PSEL_IN && PENABLE_IN;
  assign do_ans    = acc && !PREADY_OUT;
  assign do_cmt    = acc && PREADY_OUT;
  assign wr_cmt    = do_cmt && PWRITE_IN && !PSLVERR_OUT;
  assign en_locked = secure_q && !armed_q;

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (PADDR_IN)
      rvm_pkg::ADDR_CTRL: begin
        rd_data[rvm_pkg::CTRL_LOW_LSB +: SW]  = low_sel_q;
        rd_data[rvm_pkg::CTRL_HIGH_LSB +: SW] = high_sel_q;
        rd_data[rvm_pkg::CTRL_SECURE]         = secure_q;
      end
      rvm_pkg::ADDR_ENABLE: begin
        rd_data[N-1:0] = sup_en_q;
        rd_err         = PWRITE_IN && en_locked;
      end
      rvm_pkg::ADDR_KEY: begin
        rd_data = '0;
      end
      rvm_pkg::ADDR_STATUS: begin
        rd_data[N-1:0]                       = LOW_VOLTAGE_STATUS_OUT;
        rd_data[rvm_pkg::STAT_HIGH_LSB +: N] = HIGH_VOLTAGE_STATUS_OUT;
      end
      rvm_pkg::ADDR_IRQ_STAT: begin
        rd_data[N-1:0]                       = irq_low_q;
        rd_data[rvm_pkg::STAT_HIGH_LSB +: N] = irq_high_q;
      end
      rvm_pkg::ADDR_IRQ_MASK: begin
        rd_data[N-1:0]                       = irqm_low_q;
        rd_data[rvm_pkg::STAT_HIGH_LSB +: N] = irqm_high_q;
      end
      rvm_pkg::ADDR_TRIP_LOW: begin
        rd_data[2*N-1:0] = LOW_TRIP_CODE_OUT;
      end
      rvm_pkg::ADDR_TRIP_HIGH: begin
        rd_data[2*N-1:0] = HIGH_TRIP_CODE_OUT;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
    end else if (do_ans) begin
      PREADY_OUT  <= 1'b1;
      PSLVERR_OUT <= rd_err;
      PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : rd_data;
    end else begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      low_sel_q  <= rvm_pkg::LOW_SEL_RST;
      high_sel_q <= rvm_pkg::HIGH_SEL_RST;
      secure_q   <= 1'b0;
      ctrl_wr_q  <= 1'b0;
    end else if (wr_cmt && PADDR_IN == rvm_pkg::ADDR_CTRL) begin
      low_sel_q  <= PWDATA_IN[rvm_pkg::CTRL_LOW_LSB +: SW];
      high_sel_q <= PWDATA_IN[rvm_pkg::CTRL_HIGH_LSB +: SW];
      secure_q   <= PWDATA_IN[rvm_pkg::CTRL_SECURE];
      ctrl_wr_q  <= 1'b1;
    end
  end

  // ----------------------------------------
  // Secure write sequence
  // ----------------------------------------
  // Writing the key arms exactly one following write; any other write
  // disarms, so a stray access cannot leave the enables unprotected.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      armed_q <= 1'b0;
    end else if (do_cmt && PWRITE_IN) begin
      armed_q <= (PADDR_IN == rvm_pkg::ADDR_KEY) && (PWDATA_IN == rvm_pkg::SECURE_KEY);
    end
  end

  // ----------------------------------------
  // Supervise enables
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sup_en_q <= rvm_pkg::ENABLE_RST;
      en_wr_q  <= 1'b0;
    end else if (wr_cmt && PADDR_IN == rvm_pkg::ADDR_ENABLE) begin
      sup_en_q <= PWDATA_IN[N-1:0];
      en_wr_q  <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      SUPERVISE_ENABLE_OUT <= rvm_pkg::ENABLE_RST;
    end else begin
      SUPERVISE_ENABLE_OUT <= sup_en_q;
    end
  end

  // ----------------------------------------
  // Start-up masking
  // ----------------------------------------
  assign on_rise  = REG_ON_IN & ~reg_on_q;
  assign new_mask = on_rise & ~REG_READY_IN;
  assign active   = sup_en_q & ~mask_q;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      reg_on_q <= '0;
      mask_q   <= '0;
    end else begin
      reg_on_q <= REG_ON_IN;
      mask_q   <= (mask_q & ~REG_READY_IN) | new_mask;
    end
  end

  // ----------------------------------------
  // Trip code latch
  // ----------------------------------------
  // Codes are taken once, on the first edge after reset release, and
  // then held so the comparators never see a code change mid-operation.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      load_done_q        <= 1'b0;
      LOW_TRIP_CODE_OUT  <= '0;
      HIGH_TRIP_CODE_OUT <= '0;
    end else if (!load_done_q) begin
      load_done_q        <= 1'b1;
      LOW_TRIP_CODE_OUT  <= {LINEAR_LOW_TRIP_CODE_IN, SWITCHER_LOW_TRIP_CODE_IN};
      HIGH_TRIP_CODE_OUT <= {LINEAR_HIGH_TRIP_CODE_IN, SWITCHER_HIGH_TRIP_CODE_IN};
    end
  end

  // ----------------------------------------
  // Per-regulator filters
  // ----------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_reg
    rvm_filter #(
      .CNT_W (DW)
    ) u_low (
      .clk_in    (CLK_IN),
      .rst_in    (RST_IN),
      .tick_in   (tick),
      .active_in (active[i]),
      .limit_in  (low_limit),
      .cond_in   (LOW_CMP_IN[i]),
      .state_out (LOW_VOLTAGE_STATUS_OUT[i])
    );
    rvm_filter #(
      .CNT_W (DW)
    ) u_high (
      .clk_in    (CLK_IN),
      .rst_in    (RST_IN),
      .tick_in   (tick),
      .active_in (active[i]),
      .limit_in  (high_limit),
      .cond_in   (HIGH_CMP_IN[i]),
      .state_out (HIGH_VOLTAGE_STATUS_OUT[i])
    );
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // A status rise in the same cycle as its write-one clear stays set.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      low_prev_q  <= '0;
      high_prev_q <= '0;
      irq_low_q   <= '0;
      irq_high_q  <= '0;
    end else begin
      low_prev_q  <= LOW_VOLTAGE_STATUS_OUT;
      high_prev_q <= HIGH_VOLTAGE_STATUS_OUT;
      if (wr_cmt && PADDR_IN == rvm_pkg::ADDR_IRQ_STAT) begin
        irq_low_q  <= (irq_low_q & ~PWDATA_IN[N-1:0])
                      | (LOW_VOLTAGE_STATUS_OUT & ~low_prev_q);
        irq_high_q <= (irq_high_q & ~PWDATA_IN[rvm_pkg::STAT_HIGH_LSB +: N])
                      | (HIGH_VOLTAGE_STATUS_OUT & ~high_prev_q);
      end else begin
        irq_low_q  <= irq_low_q | (LOW_VOLTAGE_STATUS_OUT & ~low_prev_q);
        irq_high_q <= irq_high_q | (HIGH_VOLTAGE_STATUS_OUT & ~high_prev_q);
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irqm_low_q  <= '0;
      irqm_high_q <= '0;
    end else if (wr_cmt && PADDR_IN == rvm_pkg::ADDR_IRQ_MASK) begin
      irqm_low_q  <= PWDATA_IN[N-1:0];
      irqm_high_q <= PWDATA_IN[rvm_pkg::STAT_HIGH_LSB +: N];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |{irq_low_q & irqm_low_q, irq_high_q & irqm_high_q};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_answer;
    PREADY_OUT ##1 !PREADY_OUT;
  endsequence

  AST_APB_ANSWER: assert property (
    PSEL_IN && PENABLE_IN && !PREADY_OUT |=> s_answer)
    else $error("APB answer not given one cycle after access.");

  AST_FILTER_RESET: assert property (
    !ctrl_wr_q |-> (low_sel_q == rvm_pkg::LOW_SEL_RST)
                   && (high_sel_q == rvm_pkg::HIGH_SEL_RST)
                   && (low_limit == db_ticks(rvm_pkg::LOW_DB_US[rvm_pkg::LOW_SEL_RST])))
    else $error("Filter selects not at their reset values.");

  AST_ENABLE_RESET: assert property (
    !en_wr_q |-> sup_en_q == rvm_pkg::ENABLE_RST)
    else $error("Supervise enables not all one after reset.");

  AST_ENABLE_LOCK: assert property (
    do_cmt && PWRITE_IN && en_locked && PADDR_IN == rvm_pkg::ADDR_ENABLE
    |-> PSLVERR_OUT ##1 $stable(sup_en_q))
    else $error("Plain write changed a protected supervise enable.");

  AST_MASK_SET: assert property (
    |new_mask |=> ((mask_q & $past(new_mask)) == $past(new_mask)))
    else $error("Regulator not masked on enabling.");

  AST_STATUS_QUIET: assert property (
    ##1 ((~$past(active) & (LOW_VOLTAGE_STATUS_OUT | HIGH_VOLTAGE_STATUS_OUT)) == '0))
    else $error("Status set on an inactive monitor.");

  AST_TRIP_HOLD: assert property (
    load_done_q |=> $stable(LOW_TRIP_CODE_OUT) && $stable(HIGH_TRIP_CODE_OUT))
    else $error("Trip codes changed after the power-up load.");

  AST_IRQ_LEVEL: assert property (
    |{irq_low_q & irqm_low_q, irq_high_q & irqm_high_q} |=> IRQ_OUT)
    else $error("Interrupt output missing for an unmasked event.");
endmodule
`default_nettype wire

// ==== tb/rvm_partner.sv ====
// Behavioural comparator and regulator model facing the monitor.
`timescale 1ns/1ps
`default_nettype none
module rvm_partner #(
  parameter int RAMP = 120
) (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  // Commands from the bench
  input  wire logic [rvm_pkg::NUM_REG-1:0] low_want_in,
  input  wire logic [rvm_pkg::NUM_REG-1:0] high_want_in,
  input  wire logic [rvm_pkg::NUM_REG-1:0] on_want_in,
  // Pins toward the monitor
  output logic      [rvm_pkg::NUM_REG-1:0] low_cmp_out,
  output logic      [rvm_pkg::NUM_REG-1:0] high_cmp_out,
  output logic      [rvm_pkg::NUM_REG-1:0] reg_on_out,
  output logic      [rvm_pkg::NUM_REG-1:0] reg_ready_out
);
  int ramp_q [rvm_pkg::NUM_REG];
  // ----------------------------------------
  // Comparators
  // ----------------------------------------
  // A ramping output sits below its low trip point, so a missing mask shows up.
  assign low_cmp_out  = low_want_in | (reg_on_out & ~reg_ready_out);
  assign high_cmp_out = high_want_in;
  // ----------------------------------------
  // Regulator ramp
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_on_out    <= rvm_pkg::ENABLE_RST;
      reg_ready_out <= rvm_pkg::ENABLE_RST;
      for (int i = 0; i < rvm_pkg::NUM_REG; i++) ramp_q[i] <= RAMP;
    end else begin
      reg_on_out <= on_want_in;
      for (int i = 0; i < rvm_pkg::NUM_REG; i++) begin
        ramp_q[i]        <= on_want_in[i] ? (ramp_q[i] < RAMP ? ramp_q[i] + 1 : RAMP) : 0;
        reg_ready_out[i] <= on_want_in[i] && ramp_q[i] >= RAMP;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_regulator_voltage_monitor.sv ====
// Self-checking bench for the regulator voltage monitor.
`timescale 1ns/1ps
`default_nettype none
module test_regulator_voltage_monitor;
  localparam int T = 2;
  localparam int N = rvm_pkg::NUM_REG;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          psel = 1'b0;
  logic          pen = 1'b0;
  logic          pwr = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [N-1:0]  lcmp, hcmp, ron, rrdy, sen, lst, hst;
  logic [N-1:0]  lw = '0;
  logic [N-1:0]  hw = '0;
  logic [N-1:0]  ow = '1;
  logic [13:0]   swl, swh;
  logic [7:0]    lnl, lnh;
  logic [21:0]   lcode, hcode;
  logic          irq;
  logic [31:0]   seed = 32'h4081;
  int            fail_count = 0;
  int            samples_checked = 0;
  int            en_m = 32'h7FF;
  int            mask_m = 0;

  always #5 clk = ~clk;

  rvm_monitor #(.TICK_CYC(T)) uut (
    .CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .LOW_CMP_IN(lcmp), .HIGH_CMP_IN(hcmp), .REG_ON_IN(ron),
    .REG_READY_IN(rrdy), .SWITCHER_LOW_TRIP_CODE_IN(swl), .LINEAR_LOW_TRIP_CODE_IN(lnl),
    .SWITCHER_HIGH_TRIP_CODE_IN(swh), .LINEAR_HIGH_TRIP_CODE_IN(lnh),
    .LOW_TRIP_CODE_OUT(lcode), .HIGH_TRIP_CODE_OUT(hcode), .SUPERVISE_ENABLE_OUT(sen),
    .LOW_VOLTAGE_STATUS_OUT(lst), .HIGH_VOLTAGE_STATUS_OUT(hst), .IRQ_OUT(irq));

  rvm_partner #(.RAMP(120)) far (
    .clk_in(clk), .rst_in(rst), .low_want_in(lw), .high_want_in(hw), .on_want_in(ow),
    .low_cmp_out(lcmp), .high_cmp_out(hcmp), .reg_on_out(ron), .reg_ready_out(rrdy));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n >= 50) chk(0, 1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(e, err);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk(e, err);
  endtask

  // Drives one condition and times the debounced rise and fall in cycles.
  task automatic filt(input int ch, input bit high, input int n);
    int c;
    for (int dir = 1; dir >= 0; dir--) begin
      c = 0;
      if (high) hw[ch] <= dir[0];
      else lw[ch] <= dir[0];
      do begin
        @(posedge clk);
        c++;
      end while ((high ? hst[ch] : lst[ch]) !== dir[0] && c < 400);
      chk(32'(c >= (n - 1) * T && c <= n * T + 3), 1);
      if (dir == 1) begin
        repeat (3) @(posedge clk);
        chk(irq, mask_m != 0);
        rd(rvm_pkg::ADDR_STATUS, 32'(1) << (ch + (high ? 16 : 0)), 1'b0);
        rd(rvm_pkg::ADDR_IRQ_STAT, 32'(1) << (ch + (high ? 16 : 0)), 1'b0);
      end
    end
    wr(rvm_pkg::ADDR_IRQ_STAT, 32'h07FF_07FF, 1'b0);
    repeat (3) @(posedge clk);
    chk(irq, 0);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #300_000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    int ch;
    {swl, lnl} = 22'(rnd());
    {swh, lnh} = 22'(rnd());
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(lcode, {lnl, swl});
    chk(hcode, {lnh, swh});
    // Moving the configuration after the latch must not reach the codes.
    swl <= ~swl;
    lnh <= ~lnh;
    rd(rvm_pkg::ADDR_CTRL, 32'h2, 1'b0);
    rd(rvm_pkg::ADDR_ENABLE, 32'h7FF, 1'b0);
    rd(rvm_pkg::ADDR_TRIP_LOW, 32'({lnl, ~swl}), 1'b0);
    rd(rvm_pkg::ADDR_TRIP_HIGH, 32'({~lnh, swh}), 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    chk(sen, 11'h7FF);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      mask_m = (s % 2 == 0) ? 32'h07FF_07FF : 0;
      wr(rvm_pkg::ADDR_IRQ_MASK, mask_m, 1'b0);
      wr(rvm_pkg::ADDR_CTRL, 32'(s | (s << 2)), 1'b0);
      ch = int'(rnd() % N);
      filt(ch, 1'b0, rvm_pkg::LOW_DB_US[s]);
      filt(ch, 1'b1, rvm_pkg::HIGH_DB_US[s]);
    end
    // A short pulse must not reach the status; the counter restarts.
    wr(rvm_pkg::ADDR_CTRL, 32'h0, 1'b0);
    lw[3] <= 1'b1;
    repeat (6) @(posedge clk);
    lw[3] <= 1'b0;
    repeat (20) @(posedge clk);
    chk(lst[3], 0);
    filt(3, 1'b0, rvm_pkg::LOW_DB_US[0]);
    $display("test filter done");
    lw[5] <= 1'b1;
    hw[5] <= 1'b1;
    repeat (300) @(posedge clk);
    chk({lst[5], hst[5]}, 2'b11);
    en_m = 32'h7DF;
    wr(rvm_pkg::ADDR_ENABLE, en_m, 1'b0);
    repeat (3) @(posedge clk);
    chk({lst[5], hst[5]}, 2'b00);
    chk(sen, en_m);
    lw[5] <= 1'b0;
    hw[5] <= 1'b0;
    wr(rvm_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 1'b0);
    rd(rvm_pkg::ADDR_STATUS, 32'h0, 1'b0);
    $display("test disable done");
    wr(rvm_pkg::ADDR_CTRL, 32'h10, 1'b0);
    wr(rvm_pkg::ADDR_ENABLE, 32'h7FF, 1'b1);
    rd(rvm_pkg::ADDR_ENABLE, en_m, 1'b0);
    wr(rvm_pkg::ADDR_KEY, rvm_pkg::SECURE_KEY, 1'b0);
    wr(rvm_pkg::ADDR_ENABLE, 32'h7FF, 1'b0);
    wr(rvm_pkg::ADDR_ENABLE, 32'h7FE, 1'b1);
    rd(rvm_pkg::ADDR_ENABLE, 32'h7FF, 1'b0);
    chk(sen, 11'h7FF);
    $display("test secure done");
    ow[8] <= 1'b0;
    repeat (10) @(posedge clk);
    ow[8] <= 1'b1;
    ch = 0;
    repeat (200) begin
      @(posedge clk);
      ch += int'(lst[8] !== 1'b0);
    end
    chk(ch, 0);
    chk(rrdy[8], 1);
    $display("test masking done");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(lcode, {lnl, swl});
    chk(sen, 11'h7FF);
    rd(rvm_pkg::ADDR_CTRL, 32'h2, 1'b0);
    rd(rvm_pkg::ADDR_ENABLE, 32'h7FF, 1'b0);
    rd(rvm_pkg::ADDR_IRQ_STAT, 32'h0, 1'b0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
